// file: src/mul_top.sv
// unit decoding, scaling, limit switch reaction and software limits
`timescale 1ns/100ps
module mul_top
  import mul_pkg::*;
#(
  parameter int CUR_CYC = CUR_CYCLES,
  parameter int VEL_CYC = VEL_CYCLES,
  parameter int APP_CYC = APP_CYCLES
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  // limit switch pins
  input  wire logic        lim_pos_pin,
  input  wire logic        lim_neg_pin,
  // motion core
  input  wire logic [31:0] act_pos,
  input  wire logic        axis_still,
  input  wire logic [31:0] speed_raw,
  input  wire logic [31:0] accel_raw,
  input  wire logic [31:0] jerk_raw,
  output logic [31:0]      speed_scaled,
  output logic [31:0]      accel_scaled,
  output logic [31:0]      jerk_scaled,
  output logic [31:0]      target_pos,
  // decoded unit
  output logic [7:0]       time_unit,
  output logic [7:0]       pos_unit,
  output logic [7:0]       unit_exp,
  // drive control
  output logic [1:0]       ramp_sel,
  output logic             power_on,
  output logic             block_pos,
  output logic             block_neg,
  output logic             limit_warn,
  // task ticks
  output logic             tick_cur,
  output logic             tick_vel,
  output logic             tick_app
);

  // ==========================================================
  // task tick dividers
  localparam int PER [3] = '{CUR_CYC, VEL_CYC, APP_CYC};
  logic [31:0] tcnt_reg [3];
  logic [31:0] tcnt_next [3];
  logic [2:0]  tick_reg, tick_next;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tick_next[i] = (tcnt_reg[i] == 32'(PER[i] - 1));
      tcnt_next[i] = tick_next[i] ? 32'h0 : tcnt_reg[i] + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      tcnt_reg[i] <= rst ? 32'h0 : tcnt_next[i];
    end
    tick_reg <= rst ? 3'h0 : tick_next;
  end

  // ==========================================================
  // registers
  logic [31:0] unit_reg, unit_next, vscale_reg, vscale_next;
  logic [31:0] nd_reg [ND_COUNT];
  logic [31:0] nd_next [ND_COUNT];
  logic [31:0] nd_act_reg [ND_COUNT];
  logic [31:0] nd_act_next [ND_COUNT];
  logic [7:0]  react_reg, react_next;
  logic [3:0]  ctrl_reg, ctrl_next;
  logic [31:0] lo_reg, lo_next, hi_reg, hi_next, tgt_reg, tgt_next;
  logic [31:0] rd_reg, rd_next, clamp;
  logic [2:0]  nd_idx;
  mul_state_t  st_reg, st_next;
  logic        warn_reg;

  assign nd_idx = 3'((addr - ADDR_ND_BASE) >> 2);

  always_comb begin
    unit_next   = unit_reg;
    vscale_next = vscale_reg;
    react_next  = react_reg;
    ctrl_next   = ctrl_reg;
    lo_next     = lo_reg;
    hi_next     = hi_reg;
    tgt_next    = tgt_reg;
    rd_next     = 32'h0;
    nd_next     = nd_reg;
    nd_act_next = nd_act_reg;
    clamp       = wr_data;
    if ($signed(clamp) > $signed(hi_reg)) clamp = hi_reg;
    if ($signed(clamp) < $signed(lo_reg)) clamp = lo_reg;
    if (wr_en) begin
      unique case (addr)
        ADDR_SPD_UNIT: unit_next = {wr_data[31:8], RESV_MASK};
        ADDR_VSCALE:   vscale_next = {wr_data[31:8], RESV_MASK};
        ADDR_CTRL:     ctrl_next = wr_data[3:0];
        ADDR_LIM_LO:   lo_next = wr_data;
        ADDR_LIM_HI:   hi_next = wr_data;
        ADDR_TARGET:   tgt_next = clamp;
        ADDR_REACT: begin
          if (wr_data[7:0] inside {REACT_NONE, REACT_SLOW_LK, REACT_QUICK_LK,
                                   REACT_SLOW_HT, REACT_QUICK_HT}) begin
            react_next = wr_data[7:0];
          end
        end
        default: begin
          if (addr >= ADDR_ND_BASE && addr <= ADDR_ND_LAST && addr[1:0] == 2'h0) begin
            nd_next[nd_idx] = wr_data;
          end
        end
      endcase
    end
    if (st_reg != MUL_ST_RUN) begin
      nd_act_next = nd_reg;
    end
    if (rd_en) begin
      unique case (addr)
        ADDR_SPD_UNIT: rd_next = {unit_reg[31:8], RESV_MASK};
        ADDR_VSCALE:   rd_next = vscale_reg;
        ADDR_REACT:    rd_next = {{24{react_reg[7]}}, react_reg};
        ADDR_CTRL:     rd_next = {28'h0, ctrl_reg};
        ADDR_STAT:     rd_next = {21'h0, st_reg, warn_reg, 7'h0};
        ADDR_LIM_LO:   rd_next = lo_reg;
        ADDR_LIM_HI:   rd_next = hi_reg;
        ADDR_TARGET:   rd_next = tgt_reg;
        default: begin
          if (addr >= ADDR_ND_BASE && addr <= ADDR_ND_LAST && addr[1:0] == 2'h0) begin
            rd_next = nd_reg[nd_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_reg   <= RST_UNIT;
      vscale_reg <= RST_UNIT;
      react_reg  <= REACT_NONE;
      ctrl_reg   <= 4'h0;
      lo_reg     <= RST_LIM_LO;
      hi_reg     <= RST_LIM_HI;
      tgt_reg    <= 32'h0;
      rd_reg     <= 32'h0;
      for (int i = 0; i < ND_COUNT; i++) begin
        nd_reg[i]     <= RST_ND;
        nd_act_reg[i] <= RST_ND;
      end
    end else begin
      unit_reg   <= unit_next;
      vscale_reg <= vscale_next;
      react_reg  <= react_next;
      ctrl_reg   <= ctrl_next;
      lo_reg     <= lo_next;
      hi_reg     <= hi_next;
      tgt_reg    <= tgt_next;
      rd_reg     <= rd_next;
      nd_reg     <= nd_next;
      nd_act_reg <= nd_act_next;
    end
  end

  // ==========================================================
  // unit decode, frozen while running
  logic [31:0] eff_unit;
  logic [23:0] dec_reg, dec_next;

  assign eff_unit = ctrl_reg[CTRL_VEL_BIT] ? vscale_reg : unit_reg;

  always_comb begin
    dec_next = dec_reg;
    if (st_reg != MUL_ST_RUN) begin
      dec_next = eff_unit[31:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    dec_reg <= rst ? RST_UNIT[31:8] : dec_next;
  end

  // ==========================================================
  // scaling on each application tick
  logic [31:0] raw [3];
  logic [31:0] scl [3];
  assign raw = '{speed_raw, accel_raw, jerk_raw};

  for (genvar g = 0; g < 3; g++) begin : g_scale
    mul_scaler u_scale (
      .clk_sys (clk_sys),
      .rst     (rst),
      .start   (tick_reg[2]),
      .value   (raw[g]),
      .num     (nd_act_reg[2 * g]),
      .den     (nd_act_reg[2 * g + 1]),
      .result  (scl[g]),
      .busy    ()
    );
  end

  // ==========================================================
  // limit switches, sampled per application tick
  logic [1:0]  syn1_reg, syn2_reg, lim_reg, lim_next, blk_reg, blk_next;
  logic [31:0] lpos_reg, lpos_next;
  logic        warn_next, side_reg, side_next, qsl_reg, qsl_next;
  logic        dest_halt_reg, dest_halt_next, hit, power_reg, power_next;
  mul_ramp_t   ramp_reg, ramp_next;

  always_comb begin
    lim_next       = lim_reg;
    warn_next      = warn_reg;
    side_next      = side_reg;
    lpos_next      = lpos_reg;
    st_next        = st_reg;
    ramp_next      = ramp_reg;
    dest_halt_next = dest_halt_reg;
    qsl_next       = qsl_reg;
    hit            = 1'b0;
    blk_next[0]    = lim_reg[0] || $signed(act_pos) > $signed(hi_reg);
    blk_next[1]    = lim_reg[1] || $signed(act_pos) < $signed(lo_reg);
    if (tick_reg[2]) begin
      lim_next = syn2_reg;
      // switch must already read released at the previous tick
      if (warn_reg && !syn2_reg[side_reg] && !lim_reg[side_reg]) begin
        if (side_reg ? $signed(act_pos) > $signed(lpos_reg)
                     : $signed(act_pos) < $signed(lpos_reg)) begin
          warn_next = 1'b0;
        end
      end
      if (syn2_reg[0] && !lim_reg[0] || syn2_reg[1] && !lim_reg[1]) begin
        hit       = 1'b1;
        warn_next = 1'b1;
        side_next = !(syn2_reg[0] && !lim_reg[0]);
        lpos_next = act_pos;
      end
      unique case (st_reg)
        MUL_ST_IDLE: begin
          qsl_next = 1'b0;
          if (ctrl_reg[CTRL_EN_BIT] && ctrl_reg[CTRL_QS_BIT]) st_next = MUL_ST_RUN;
        end
        MUL_ST_RUN: begin
          if (!ctrl_reg[CTRL_EN_BIT]) begin
            st_next = MUL_ST_IDLE;
          end else if (hit && react_reg != REACT_NONE) begin
            st_next        = MUL_ST_BRAKE;
            ramp_next      = react_reg[0] ? MUL_RAMP_SLOW : MUL_RAMP_QUICK;
            dest_halt_next = react_reg[2];
          end
        end
        MUL_ST_BRAKE: begin
          if (axis_still) begin
            ramp_next = MUL_RAMP_NONE;
            qsl_next  = 1'b0;
            st_next   = dest_halt_reg ? MUL_ST_HALT : MUL_ST_LOCKED;
          end
        end
        MUL_ST_HALT: begin
          if (!ctrl_reg[CTRL_QS_BIT]) qsl_next = 1'b1;
          if (!ctrl_reg[CTRL_EN_BIT]) begin
            st_next = MUL_ST_IDLE;
          end else if (qsl_reg && ctrl_reg[CTRL_QS_BIT]) begin
            st_next = MUL_ST_RUN;
          end
        end
        MUL_ST_LOCKED: begin
          if (!ctrl_reg[CTRL_EN_BIT]) st_next = MUL_ST_IDLE;
        end
        default: st_next = MUL_ST_IDLE;
      endcase
    end
    power_next = st_next inside {MUL_ST_RUN, MUL_ST_BRAKE, MUL_ST_HALT};
  end

  always_ff @(posedge clk_sys) begin
    syn1_reg <= rst ? 2'h0 : {lim_neg_pin, lim_pos_pin};
    syn2_reg <= rst ? 2'h0 : syn1_reg;
    if (rst) begin
      lim_reg       <= 2'h0;
      blk_reg       <= 2'h0;
      warn_reg      <= 1'b0;
      side_reg      <= 1'b0;
      lpos_reg      <= 32'h0;
      st_reg        <= MUL_ST_IDLE;
      ramp_reg      <= MUL_RAMP_NONE;
      dest_halt_reg <= 1'b0;
      qsl_reg       <= 1'b0;
      power_reg     <= 1'b0;
    end else begin
      lim_reg       <= lim_next;
      blk_reg       <= blk_next;
      warn_reg      <= warn_next;
      side_reg      <= side_next;
      lpos_reg      <= lpos_next;
      st_reg        <= st_next;
      ramp_reg      <= ramp_next;
      dest_halt_reg <= dest_halt_next;
      qsl_reg       <= qsl_next;
      power_reg     <= power_next;
    end
  end

  // ==========================================================
  // outputs
  assign rd_data      = rd_reg;
  assign speed_scaled = scl[0];
  assign accel_scaled = scl[1];
  assign jerk_scaled  = scl[2];
  assign target_pos   = tgt_reg;
  assign time_unit    = dec_reg[7:0];
  assign pos_unit     = dec_reg[15:8];
  assign unit_exp     = dec_reg[23:16];
  assign ramp_sel     = ramp_reg;
  assign power_on     = power_reg;
  assign block_pos    = blk_reg[0];
  assign block_neg    = blk_reg[1];
  assign limit_warn   = warn_reg;
  assign {tick_app, tick_vel, tick_cur} = tick_reg;

  // ==========================================================
  // checks
  sequence s_brake_done;
    tick_reg[2] && st_reg == MUL_ST_BRAKE && axis_still;
  endsequence

  AST_RESV_LOW: assert property (@(posedge clk_sys) disable iff (rst)
    rd_en && addr == ADDR_SPD_UNIT |=> rd_data[7:0] == 8'h00)
    else $error("reserved unit byte read nonzero");
  AST_UNIT_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg != MUL_ST_RUN && !ctrl_reg[CTRL_VEL_BIT] |=> time_unit == $past(unit_reg[15:8]))
    else $error("time unit not decoded from bits 8 to 15");
  AST_VEL_UNIT: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg != MUL_ST_RUN && ctrl_reg[CTRL_VEL_BIT] |=> unit_exp == $past(vscale_reg[31:24]))
    else $error("velocity mode unit not from scale object");
  AST_RUN_FREEZE: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg == MUL_ST_RUN && $past(st_reg) == MUL_ST_RUN |-> $stable(dec_reg) && $stable(nd_act_reg[0]))
    else $error("units changed while running");
  AST_WARN_SET: assert property (@(posedge clk_sys) disable iff (rst)
    tick_reg[2] && syn2_reg[0] && !lim_reg[0] |=> limit_warn ##1 limit_warn)
    else $error("limit warning not raised");
  AST_WARN_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    limit_warn && lim_reg[side_reg] |=> limit_warn)
    else $error("warning cleared while switch active");
  AST_BLOCK: assert property (@(posedge clk_sys) disable iff (rst)
    lim_reg[0] && !lim_reg[1] && $signed(act_pos) >= $signed(lo_reg) |=> block_pos && !block_neg)
    else $error("wrong direction blocked");
  AST_CLAMP: assert property (@(posedge clk_sys) disable iff (rst)
    wr_en && addr == ADDR_TARGET && $signed(lo_reg) <= $signed(hi_reg)
    |=> $signed(target_pos) <= $signed(hi_reg) && $signed(target_pos) >= $signed(lo_reg))
    else $error("target outside software limits");
  AST_REACT_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
    wr_en && addr == ADDR_REACT && wr_data[7:0] == 8'h03 |=> $stable(react_reg))
    else $error("illegal reaction code accepted");
  AST_QS_KEPT: assert property (@(posedge clk_sys) disable iff (rst)
    !(wr_en && addr == ADDR_CTRL) |=> $stable(ctrl_reg))
    else $error("control word changed without a write");
  AST_BRAKE_END: assert property (@(posedge clk_sys) disable iff (rst)
    s_brake_done and dest_halt_reg |=> st_reg == MUL_ST_HALT && power_on ##1 power_on)
    else $error("brake did not end in quick halt");
  AST_APP_TICK: assert property (@(posedge clk_sys) disable iff (rst)
    tick_app |=> !tick_app [*8])
    else $error("application tick repeats too soon");

endmodule : mul_top

// file: src/mul_pkg.sv
// constants for the motion units and limit handling block
package mul_pkg;

  // ==========================================================
  // clock and task periods
  localparam int CLK_PERIOD_NS = 10;
  localparam int CUR_PERIOD_NS = 62500;
  localparam int VEL_PERIOD_NS = 250000;
  localparam int APP_PERIOD_NS = 1000000;
  localparam int CUR_CYCLES    = CUR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int VEL_CYCLES    = VEL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int APP_CYCLES    = APP_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register offsets
  localparam logic [15:0] ADDR_SPD_UNIT = 16'h60a9;
  localparam logic [15:0] ADDR_VSCALE   = 16'h0100;
  localparam logic [15:0] ADDR_ND_BASE  = 16'h0104;
  localparam logic [15:0] ADDR_ND_LAST  = 16'h0118;
  localparam logic [15:0] ADDR_REACT    = 16'h011c;
  localparam logic [15:0] ADDR_CTRL     = 16'h0120;
  localparam logic [15:0] ADDR_STAT     = 16'h0124;
  localparam logic [15:0] ADDR_LIM_LO   = 16'h0128;
  localparam logic [15:0] ADDR_LIM_HI   = 16'h012c;
  localparam logic [15:0] ADDR_TARGET   = 16'h0130;
  localparam int          ND_COUNT      = 6;

  // ==========================================================
  // reset values and field positions
  localparam logic [31:0] RST_UNIT      = 32'h00b44700;
  localparam logic [31:0] RST_ND        = 32'h00000001;
  localparam logic [31:0] RST_LIM_LO    = 32'h80000000;
  localparam logic [31:0] RST_LIM_HI    = 32'h7fffffff;
  localparam logic [7:0]  RESV_MASK     = 8'h00;
  localparam int          TIME_LSB      = 8;
  localparam int          POS_LSB       = 16;
  localparam int          EXP_LSB       = 24;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_QS_BIT   = 2;
  localparam int          CTRL_VEL_BIT  = 3;
  localparam int          STAT_WARN_BIT = 7;

  // ==========================================================
  // limit reaction codes
  localparam logic [7:0] REACT_NONE    = 8'hff;
  localparam logic [7:0] REACT_SLOW_LK = 8'h01;
  localparam logic [7:0] REACT_QUICK_LK = 8'h02;
  localparam logic [7:0] REACT_SLOW_HT = 8'h05;
  localparam logic [7:0] REACT_QUICK_HT = 8'h06;

  typedef enum logic [1:0] {
    MUL_RAMP_NONE  = 2'h0,
    MUL_RAMP_SLOW  = 2'h1,
    MUL_RAMP_QUICK = 2'h2
  } mul_ramp_t;

  typedef enum logic [2:0] {
    MUL_ST_IDLE   = 3'h0,
    MUL_ST_RUN    = 3'h1,
    MUL_ST_BRAKE  = 3'h3,
    MUL_ST_HALT   = 3'h2,
    MUL_ST_LOCKED = 3'h6
  } mul_state_t;

endpackage : mul_pkg

// file: src/mul_scaler.sv
// value times numerator over denominator, one bit per cycle
`timescale 1ns/100ps
module mul_scaler
  import mul_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // request
  input  wire logic        start,
  input  wire logic [31:0] value,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  // answer
  output logic [31:0]      result,
  output logic             busy
);

  logic [63:0] dvd_reg, dvd_next;
  logic [32:0] rem_reg, rem_next;
  logic [31:0] den_reg, den_next;
  logic [31:0] res_reg, res_next;
  logic [6:0]  cnt_reg, cnt_next;
  logic        neg_reg, neg_next;
  logic        busy_reg, busy_next;
  logic [32:0] rem_sh;
  logic [31:0] mag;

  always_comb begin
    dvd_next  = dvd_reg;
    rem_next  = rem_reg;
    den_next  = den_reg;
    res_next  = res_reg;
    cnt_next  = cnt_reg;
    neg_next  = neg_reg;
    busy_next = busy_reg;
    mag       = value[31] ? 32'(-value) : value;
    rem_sh    = {rem_reg[31:0], dvd_reg[63]};
    if (!busy_reg) begin
      // a zero denominator keeps the previous result
      if (start && den != 32'h0) begin
        dvd_next  = 64'(mag) * 64'(num);
        rem_next  = 33'h0;
        den_next  = den;
        neg_next  = value[31];
        cnt_next  = 7'h0;
        busy_next = 1'b1;
      end
    end else begin
      if (rem_sh >= {1'b0, den_reg}) begin
        rem_next = rem_sh - {1'b0, den_reg};
        dvd_next = {dvd_reg[62:0], 1'b1};
      end else begin
        rem_next = rem_sh;
        dvd_next = {dvd_reg[62:0], 1'b0};
      end
      cnt_next = cnt_reg + 7'h1;
      if (cnt_reg == 7'h3f) begin
        busy_next = 1'b0;
        res_next  = neg_reg ? 32'(-dvd_next[31:0]) : dvd_next[31:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dvd_reg  <= 64'h0;
      rem_reg  <= 33'h0;
      den_reg  <= 32'h1;
      res_reg  <= 32'h0;
      cnt_reg  <= 7'h0;
      neg_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      dvd_reg  <= dvd_next;
      rem_reg  <= rem_next;
      den_reg  <= den_next;
      res_reg  <= res_next;
      cnt_reg  <= cnt_next;
      neg_reg  <= neg_next;
      busy_reg <= busy_next;
    end
  end

  assign result = res_reg;
  assign busy   = busy_reg;

endmodule : mul_scaler

// file: testbench/mul_axis_model.sv
// axis model: moves by a commanded step on each application tick
`timescale 1ns/100ps
module mul_axis_model #(
  parameter int SW_POS = 50
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // command from the drive
  input  wire logic [31:0] vel,
  input  wire logic        tick_app,
  input  wire logic [1:0]  ramp_sel,
  input  wire logic        block_pos,
  input  wire logic        block_neg,
  // feedback to the drive
  output logic [31:0]      act_pos,
  output logic             axis_still,
  output logic             lim_pos_pin,
  output logic             lim_neg_pin
);
  logic move;
  // a ramp stops the axis at once; refused directions do not move
  assign move = (ramp_sel == 2'h0) && (vel != 32'h0) &&
                !(block_pos && !vel[31]) && !(block_neg && vel[31]);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_pos    <= 32'h0;
      axis_still <= 1'b1;
    end else if (tick_app) begin
      axis_still <= !move;
      if (move) begin
        act_pos <= act_pos + vel;
      end
    end
  end
  assign lim_pos_pin = $signed(act_pos) >= SW_POS;
  assign lim_neg_pin = $signed(act_pos) <= -SW_POS;
endmodule : mul_axis_model

// file: testbench/mul_top_test.sv
// self-checking bench for unit decoding, scaling and limit handling
`timescale 1ns/100ps
module mul_top_test;
  import mul_pkg::*;
  localparam int APP = 80;
  logic        clk_sys, rst, wr_en, rd_en, axis_still, power_on, limit_warn;
  logic        lim_pos_pin, lim_neg_pin, block_pos, block_neg, tick_cur, tick_vel, tick_app;
  logic [15:0] addr;
  logic [31:0] wr_data, rd_data, vel, d, act_pos, target_pos;
  logic [31:0] speed_raw, accel_raw, jerk_raw, speed_scaled, accel_scaled, jerk_scaled;
  logic [7:0]  time_unit, pos_unit, unit_exp;
  logic [1:0]  ramp_sel;
  int          n_errors, checked, nc, nv, na;
  logic [31:0] nd [6] = '{32'h3, 32'h2, 32'h5, 32'h4, 32'h1, 32'h3};
  logic [7:0]  codes [5] = '{8'hff, 8'h01, 8'h02, 8'h05, 8'h06};

  mul_top #(.CUR_CYC(4), .VEL_CYC(16), .APP_CYC(APP)) i_mul_top (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .lim_pos_pin(lim_pos_pin),
    .lim_neg_pin(lim_neg_pin), .act_pos(act_pos), .axis_still(axis_still),
    .speed_raw(speed_raw), .accel_raw(accel_raw), .jerk_raw(jerk_raw),
    .speed_scaled(speed_scaled), .accel_scaled(accel_scaled),
    .jerk_scaled(jerk_scaled), .target_pos(target_pos), .time_unit(time_unit),
    .pos_unit(pos_unit), .unit_exp(unit_exp), .ramp_sel(ramp_sel),
    .power_on(power_on), .block_pos(block_pos), .block_neg(block_neg),
    .limit_warn(limit_warn), .tick_cur(tick_cur), .tick_vel(tick_vel),
    .tick_app(tick_app));

  mul_axis_model i_mul_axis_model (
    .clk_sys(clk_sys), .rst(rst), .vel(vel), .tick_app(tick_app),
    .ramp_sel(ramp_sel), .block_pos(block_pos), .block_neg(block_neg),
    .act_pos(act_pos), .axis_still(axis_still), .lim_pos_pin(lim_pos_pin),
    .lim_neg_pin(lim_neg_pin));

  // ==========================================================
  // tasks
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask : rd

  // waits for n application ticks, bounded
  task automatic wait_ticks(input int n);
    int k;
    k = 0;
    for (int c = 0; c < n * APP + 20 && k < n; c++) begin
      @(posedge clk_sys);
      #1;
      if (tick_app === 1'b1) k++;
    end
    if (k < n) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_ticks

  task automatic wait_warn(input logic v);
    int c;
    c = 0;
    while (limit_warn !== v && c < 40 * APP) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    if (c >= 40 * APP) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_warn

  // ==========================================================
  // stimulus
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    {rst, wr_en, rd_en, addr, wr_data} = {1'b1, 1'b0, 1'b0, 16'h0, 32'h0};
    {vel, speed_raw, accel_raw, jerk_raw} = {32'h0, 32'h64, 32'h28, 32'hfffffff4};
    {n_errors, checked, nc, nv, na} = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_SPD_UNIT, d);
    chk(d, 32'h00b44700);
    chk({unit_exp, pos_unit, time_unit}, 24'h00b447);
    rd(ADDR_REACT, d);
    chk(d, 32'hffffffff);
    for (int c = 0; c < 160; c++) begin
      @(posedge clk_sys);
      #1;
      nc += tick_cur;
      nv += tick_vel;
      na += tick_app;
    end
    chk({nc[7:0], nv[7:0], na[7:0]}, 24'h280a02);
    wr(ADDR_SPD_UNIT, 32'hfd0103ab);
    rd(ADDR_SPD_UNIT, d);
    chk(d, 32'hfd010300);
    chk({unit_exp, pos_unit, time_unit}, 24'hfd0103);
    wr(ADDR_CTRL, 32'h8);
    repeat (3) @(posedge clk_sys);
    chk(time_unit, 8'h47);
    wr(ADDR_CTRL, 32'h0);
    rd(16'h0200, d);
    chk(d, 32'h0);
    foreach (codes[i]) begin
      wr(ADDR_REACT, {24'h0, codes[i]});
      rd(ADDR_REACT, d);
      chk(d, {{24{codes[i][7]}}, codes[i]});
    end
    wr(ADDR_REACT, 32'h3);
    rd(ADDR_REACT, d);
    chk(d, 32'h6);
    for (int i = 0; i < 6; i++) wr(ADDR_ND_BASE + 16'(4 * i), nd[i]);
    wait_ticks(1);
    repeat (70) @(posedge clk_sys);
    chk(speed_scaled, 32'h96);
    chk(accel_scaled, 32'h32);
    chk(jerk_scaled, 32'hfffffffc);
    // ==========================================================
    // limit switch with halt reaction
    wr(ADDR_CTRL, 32'h5);
    wait_ticks(2);
    vel <= 32'ha;
    wait_warn(1'b1);
    chk(ramp_sel, 2'h2);
    wait_ticks(4);
    rd(ADDR_STAT, d);
    chk(d[10:7], 4'h5);
    chk({power_on, block_pos, block_neg}, 3'b110);
    rd(ADDR_CTRL, d);
    chk(d, 32'h5);
    wr(ADDR_CTRL, 32'h1);
    wait_ticks(2);
    wr(ADDR_CTRL, 32'h5);
    wait_ticks(3);
    rd(ADDR_STAT, d);
    chk(d[10:7], 4'h3);
    vel <= 32'hfffffff6;
    wait_warn(1'b0);
    chk(lim_pos_pin, 1'b0);
    vel <= 32'h0;
    wr(ADDR_ND_BASE, 32'h7);
    wait_ticks(2);
    repeat (70) @(posedge clk_sys);
    chk(speed_scaled, 32'h96);
    wr(ADDR_CTRL, 32'h0);
    wait_ticks(2);
    repeat (70) @(posedge clk_sys);
    chk(speed_scaled, 32'h15e);
    // ==========================================================
    // limit switch with locking reaction
    wr(ADDR_REACT, 32'h1);
    wr(ADDR_CTRL, 32'h5);
    wait_ticks(2);
    vel <= 32'ha;
    wait_warn(1'b1);
    chk(ramp_sel, 2'h1);
    wait_ticks(4);
    rd(ADDR_STAT, d);
    chk(d[10:7], 4'hd);
    chk({power_on, ramp_sel}, 3'b000);
    vel <= 32'hfffffff6;
    wait_warn(1'b0);
    vel <= 32'h0;
    wr(ADDR_CTRL, 32'h0);
    wait_ticks(2);
    // ==========================================================
    // software limits
    wr(ADDR_LIM_LO, 32'hffffff9c);
    wr(ADDR_LIM_HI, 32'h64);
    wr(ADDR_TARGET, 32'h1f4);
    rd(ADDR_TARGET, d);
    chk(d, 32'h64);
    wr(ADDR_TARGET, 32'hffffff00);
    rd(ADDR_TARGET, d);
    chk(d, 32'hffffff9c);
    chk(target_pos, 32'hffffff9c);
    wr(ADDR_LIM_LO, 32'h64);
    wr(ADDR_LIM_HI, 32'hc8);
    repeat (3) @(posedge clk_sys);
    chk({block_pos, block_neg}, 2'b01);
    print_verdict();
  end
endmodule : mul_top_test
